//--- include/scoe_defs.vh
// Purpose: Constants of the serial channel run-status and output-gate register bank.
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
// Notes: Behaviour
`ifndef SCOE_DEFS_VH
`define SCOE_DEFS_VH
`define SCOE_OFS_RUN0 8'h00
`define SCOE_OFS_RUN1 8'h04
`define SCOE_OFS_GATE0 8'h08
`define SCOE_OFS_GATE1 8'h0C
`define SCOE_OFS_START0 8'h10
`define SCOE_OFS_START1 8'h14
`define SCOE_OFS_STOP0 8'h18
`define SCOE_OFS_STOP1 8'h1C
`define SCOE_OFS_CLK0 8'h20
`define SCOE_OFS_CLK1 8'h24
`define SCOE_OFS_DAT0 8'h28
`define SCOE_OFS_DAT1 8'h2C
`define SCOE_RUN0_MASK 4'hF
`define SCOE_RUN1_MASK 4'h3
`define SCOE_GATE0_MASK 4'h5
`define SCOE_GATE1_MASK 4'h1
`define SCOE_RESET_RUN 4'h0
`define SCOE_RESET_GATE 4'h0
`define SCOE_RESET_LEVEL 4'hF
`define SCOE_RESP_OKAY 2'h0
`define SCOE_RESP_SLVERR 2'h2
`endif

//--- design/scoe_bank.v
// Purpose: Run-status and output-gate registers of two serial units, AXI4-Lite slave.
// Assumes: Engine level inputs come from logic on clk_sys.
// Notes: Unit 0 has four channels, unit 1 has two.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "scoe_defs.vh"
module scoe_bank (
  input wire clk_sys,
  input wire rst,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [7:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire [3:0] engine_clk0,
  input wire [3:0] engine_clk1,
  input wire [3:0] engine_dat0,
  input wire [3:0] engine_dat1,
  output reg [3:0] channel_run0,
  output reg [3:0] channel_run1,
  output reg [3:0] serial_output_gate0,
  output reg [3:0] serial_output_gate1,
  output reg [3:0] clock_pin0,
  output reg [3:0] clock_pin1,
  output reg [3:0] data_pin0,
  output reg [3:0] data_pin1
);

  reg [7:0] wr_addr;
  reg have_aw;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg have_w;
  reg [3:0] clk_sw0;
  reg [3:0] clk_sw1;
  reg [3:0] dat_sw0;
  reg [3:0] dat_sw1;
  reg [3:0] next_run0;
  reg [3:0] next_run1;
  reg [31:0] next_rdata;
  reg next_rerr;
  wire wr_go;

  // Only the byte lane 0 strobe enables a trigger write; it covers the masked low four data bits.
  function [3:0] lane0;
    input [31:0] d;
    input [3:0] s;
    input [3:0] m;
    begin
      lane0 = s[0] ? (d[3:0] & m) : 4'h0;
    end
  endfunction

  function is_known;
    input [7:0] a;
    begin
      is_known = (a[7:2] <= 6'h0B) && (a[1:0] == 2'h0);
    end
  endfunction

  assign wr_go = have_aw && have_w && !s_axi_bvalid;

  always @(posedge clk_sys) begin
    if (rst) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCOE_RESP_OKAY;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_known(wr_addr) ? `SCOE_RESP_OKAY : `SCOE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Stop is applied after start, so a simultaneous pair leaves the channel stopped.
  always @* begin
    next_run0 = channel_run0;
    next_run1 = channel_run1;
    if (wr_go && wr_addr == `SCOE_OFS_START0) begin
      next_run0 = next_run0 | lane0(wr_data, wr_strb, `SCOE_RUN0_MASK);
    end
    if (wr_go && wr_addr == `SCOE_OFS_START1) begin
      next_run1 = next_run1 | lane0(wr_data, wr_strb, `SCOE_RUN1_MASK);
    end
    if (wr_go && wr_addr == `SCOE_OFS_STOP0) begin
      next_run0 = next_run0 & ~lane0(wr_data, wr_strb, `SCOE_RUN0_MASK);
    end
    if (wr_go && wr_addr == `SCOE_OFS_STOP1) begin
      next_run1 = next_run1 & ~lane0(wr_data, wr_strb, `SCOE_RUN1_MASK);
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      channel_run0 <= `SCOE_RESET_RUN;
      channel_run1 <= `SCOE_RESET_RUN;
      serial_output_gate0 <= `SCOE_RESET_GATE;
      serial_output_gate1 <= `SCOE_RESET_GATE;
      clk_sw0 <= `SCOE_RESET_LEVEL;
      clk_sw1 <= `SCOE_RESET_LEVEL;
      dat_sw0 <= `SCOE_RESET_LEVEL;
      dat_sw1 <= `SCOE_RESET_LEVEL;
    end else begin
      channel_run0 <= next_run0 & `SCOE_RUN0_MASK;
      channel_run1 <= next_run1 & `SCOE_RUN1_MASK;
      if (wr_go && wr_addr == `SCOE_OFS_GATE0 && wr_strb[0]) begin
        serial_output_gate0 <= wr_data[3:0] & `SCOE_GATE0_MASK;
      end
      if (wr_go && wr_addr == `SCOE_OFS_GATE1 && wr_strb[0]) begin
        serial_output_gate1 <= wr_data[3:0] & `SCOE_GATE1_MASK;
      end
      // Software level bits follow the pin one cycle late while the engine owns it, so a handover returns the pin to its level one cycle before the last engine level.
      clk_sw0 <= (channel_run0 & clock_pin0) | (~channel_run0 & clk_sw0);
      clk_sw1 <= (channel_run1 & clock_pin1) | (~channel_run1 & clk_sw1);
      dat_sw0 <= (serial_output_gate0 & data_pin0) | (~serial_output_gate0 & dat_sw0);
      dat_sw1 <= (serial_output_gate1 & data_pin1) | (~serial_output_gate1 & dat_sw1);
      if (wr_go && wr_addr == `SCOE_OFS_CLK0 && wr_strb[0]) begin
        clk_sw0 <= (channel_run0 & clock_pin0) | (~channel_run0 & wr_data[3:0]);
      end
      if (wr_go && wr_addr == `SCOE_OFS_CLK1 && wr_strb[0]) begin
        clk_sw1 <= (channel_run1 & clock_pin1) | (~channel_run1 & wr_data[3:0]);
      end
      if (wr_go && wr_addr == `SCOE_OFS_DAT0 && wr_strb[0]) begin
        dat_sw0 <= (serial_output_gate0 & data_pin0) | (~serial_output_gate0 & wr_data[3:0]);
      end
      if (wr_go && wr_addr == `SCOE_OFS_DAT1 && wr_strb[0]) begin
        dat_sw1 <= (serial_output_gate1 & data_pin1) | (~serial_output_gate1 & wr_data[3:0]);
      end
    end
  end

  // Pins: engine level while owned, otherwise the software level.
  always @(posedge clk_sys) begin
    if (rst) begin
      clock_pin0 <= `SCOE_RESET_LEVEL;
      clock_pin1 <= `SCOE_RESET_LEVEL;
      data_pin0 <= `SCOE_RESET_LEVEL;
      data_pin1 <= `SCOE_RESET_LEVEL;
    end else begin
      clock_pin0 <= (channel_run0 & engine_clk0) | (~channel_run0 & clk_sw0);
      clock_pin1 <= (channel_run1 & engine_clk1) | (~channel_run1 & clk_sw1);
      data_pin0 <= (serial_output_gate0 & engine_dat0) | (~serial_output_gate0 & dat_sw0);
      data_pin1 <= (serial_output_gate1 & engine_dat1) | (~serial_output_gate1 & dat_sw1);
    end
  end

  // Trigger registers read as zero; run-status is read only.
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `SCOE_OFS_RUN0: next_rdata = {28'h0000000, channel_run0};
      `SCOE_OFS_RUN1: next_rdata = {28'h0000000, channel_run1};
      `SCOE_OFS_GATE0: next_rdata = {28'h0000000, serial_output_gate0};
      `SCOE_OFS_GATE1: next_rdata = {28'h0000000, serial_output_gate1};
      `SCOE_OFS_START0: next_rdata = 32'h00000000;
      `SCOE_OFS_START1: next_rdata = 32'h00000000;
      `SCOE_OFS_STOP0: next_rdata = 32'h00000000;
      `SCOE_OFS_STOP1: next_rdata = 32'h00000000;
      `SCOE_OFS_CLK0: next_rdata = {28'h0000000, clk_sw0};
      `SCOE_OFS_CLK1: next_rdata = {28'h0000000, clk_sw1};
      `SCOE_OFS_DAT0: next_rdata = {28'h0000000, dat_sw0};
      `SCOE_OFS_DAT1: next_rdata = {28'h0000000, dat_sw1};
      default: next_rerr = 1'b1;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCOE_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? `SCOE_RESP_SLVERR : `SCOE_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // scoe_bank
`default_nettype wire

//--- tb/scoe_bank_chk.sv
// Purpose: Port assertions for the run-status and output-gate bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Pins follow their owner one cycle later.
`timescale 1ns/100ps
`default_nettype none
module scoe_bank_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0] engine_clk0, engine_clk1, engine_dat0, engine_dat1,
  input wire logic [3:0] channel_run0, channel_run1, serial_output_gate0, serial_output_gate1,
  input wire logic [3:0] clock_pin0, clock_pin1, data_pin0, data_pin1
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  property p_run_rst; $fell(rst) |-> {channel_run1, channel_run0} == 8'h00; endproperty
  property p_gate_rst; $fell(rst) |-> {serial_output_gate1, serial_output_gate0} == 8'h00; endproperty
  property p_unused;
    {channel_run1[3:2], serial_output_gate0[3], serial_output_gate0[1], serial_output_gate1[3:1]} == 7'h00;
  endproperty
  property p_clk_owner;
    !$past(rst) |-> (({clock_pin1, clock_pin0} ^ $past({engine_clk1, engine_clk0}))
      & $past({channel_run1, channel_run0})) == 8'h00;
  endproperty
  property p_dat_owner;
    !$past(rst) |-> (({data_pin1, data_pin0} ^ $past({engine_dat1, engine_dat0}))
      & $past({serial_output_gate1, serial_output_gate0})) == 8'h00;
  endproperty
  property p_run_src; $changed({channel_run1, channel_run0}) |-> s_wr_done; endproperty
  property p_gate_src; $changed({serial_output_gate1, serial_output_gate0}) |-> s_wr_done; endproperty
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_run_rst: assert property (p_run_rst) else $error("run status not clear after reset");
  a_gate_rst: assert property (p_gate_rst) else $error("output gate not clear after reset");
  a_unused: assert property (p_unused) else $error("unimplemented bit set");
  a_clk_owner: assert property (p_clk_owner) else $error("clock pin not engine level");
  a_dat_owner: assert property (p_dat_owner) else $error("data pin not engine level");
  a_run_src: assert property (p_run_src) else $error("run status changed without write");
  a_gate_src: assert property (p_gate_src) else $error("gate changed without write");
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
endmodule // scoe_bank_chk
bind scoe_bank scoe_bank_chk scoe_bank_chk_inst (.clk_sys, .rst, .s_axi_bvalid, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .engine_clk0, .engine_clk1, .engine_dat0, .engine_dat1,
  .channel_run0, .channel_run1, .serial_output_gate0, .serial_output_gate1,
  .clock_pin0, .clock_pin1, .data_pin0, .data_pin1);
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: AXI4-Lite master tasks, table of ordinary cases.
// Notes: Awkward cases follow the table.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] engine_clk0 = 4'h0, engine_clk1 = 4'h0, engine_dat0 = 4'h0, engine_dat1 = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] channel_run0, channel_run1, serial_output_gate0, serial_output_gate1;
  wire [3:0] clock_pin0, clock_pin1, data_pin0, data_pin1;
  integer bad_count = 0, cmp_count = 0, cyc = 0, i;
  logic [23:0] rows [8];
  logic [1:0] resp;
  logic [31:0] got;
  always #10 clk_sys = ~clk_sys;
  scoe_bank scoe_bank_inst (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .engine_clk0, .engine_clk1, .engine_dat0, .engine_dat1,
    .channel_run0, .channel_run1, .serial_output_gate0, .serial_output_gate1,
    .clock_pin0, .clock_pin1, .data_pin0, .data_pin1);
  task conclude;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [3:0] d);
    begin
      @(posedge clk_sys);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {28'h0, d};
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
      while (s_axi_awvalid | s_axi_wvalid) begin
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        @(posedge clk_sys);
      end
      while (!s_axi_bvalid) @(posedge clk_sys);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      @(posedge clk_sys);
      while (s_axi_arvalid) begin
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        @(posedge clk_sys);
      end
      while (!s_axi_rvalid) @(posedge clk_sys);
      got = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task reset_check;
    begin
      for (i = 0; i < 16; i = i + 4) begin
        rd(i[7:0]);
        chk(32'h0, got, "reset");
      end
      chk(32'hF, {28'h0, clock_pin0 & clock_pin1 & data_pin0 & data_pin1}, "pins");
      $display("reset test done");
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      conclude;
    end
  end
  initial begin
    // Rows: write offset, write value, read offset, expected read value.
    // Gate rows write zero to the unimplemented gate bits.
    rows = '{24'h10F00F, 24'h18500A, 24'h14F043, 24'h1C1042,
      24'h085085, 24'h0C10C1, 24'h00000A, 24'h100100};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    reset_check;
    for (i = 0; i < 8; i = i + 1) begin
      wr(rows[i][23:16], rows[i][15:12]);
      rd(rows[i][11:4]);
      chk({28'h0, rows[i][3:0]}, got, "table");
    end
    $display("table test done");
    wr(8'h30, 4'hF);
    chk(32'h2, {30'h0, resp}, "bresp");
    rd(8'h30);
    chk(32'h2, {30'h0, resp}, "rresp");
    chk(32'h0, got, "rdata");
    $display("unmapped test done");
    wr(8'h24, 4'h2);
    repeat (2) @(posedge clk_sys);
    chk(32'h0, {30'h0, clock_pin1[1:0]}, "clk1");
    engine_clk1 <= 4'hF;
    wr(8'h28, 4'hA);
    repeat (2) @(posedge clk_sys);
    chk(32'hA, {28'h0, data_pin0}, "dat0");
    chk(32'h2, {30'h0, clock_pin1[1:0]}, "clk1");
    engine_dat0 <= 4'hF;
    repeat (3) @(posedge clk_sys);
    chk(32'hF, {28'h0, data_pin0}, "dat0");
    $display("pin test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    reset_check;
    conclude;
  end
endmodule // tb
`default_nettype wire
